/* File: src/scbl_master.sv */
`timescale 1ns/1ps
module scbl_master (
  input wire logic core_clk,
  input wire logic srst,
  scbl_if.master bus,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [20:0] req_addr,
  input wire logic [34:0] req_data,
  output logic busy
);
  typedef enum {ST_IDLE, ST_PRE, ST_SHIFT, ST_GAP1, ST_LOAD, ST_GAP2, ST_CFG} scbl_st_t;
  scbl_st_t st_q;
  logic [3:0] div_q;
  logic tick;
  logic ph_q;
  logic [4:0] bit_q;
  logic [1:0] cnt_q;
  logic [1:0] word_q;
  logic [19:0] sh_q;
  logic [20:0] a_q;
  logic [34:0] d_q;
  logic [19:0] word;
  assign tick = (div_q == scbl_pkg::HALF_CNT);
  assign req_ready = (st_q == ST_IDLE);
  assign busy = (st_q != ST_IDLE);
  // RULE5: fixed word order, RULE2 zero pad
  always_comb begin
    case (word_q)
      2'h0: word = {2'b00, 15'h0000, a_q[20:18]};
      2'h1: word = {2'b10, a_q[17:0]};
      2'h2: word = {2'b01, 1'b0, d_q[34:18]};
      default: word = {2'b11, d_q[17:0]};
    endcase
  end
  // Clock divider
  always_ff @(posedge core_clk) begin
    if (srst || st_q == ST_IDLE) begin
      div_q <= 4'h0;
    end else begin
      div_q <= tick ? 4'h0 : div_q + 4'h1;
    end
  end
  // RULE14: master alone drives bus lines other than MISO
  // Sequencer; each phase step is half a serial period
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_q <= ST_IDLE;
      ph_q <= 1'b0;
      bit_q <= 5'h00;
      cnt_q <= 2'h0;
      word_q <= 2'h0;
      sh_q <= 20'h00000;
      a_q <= 21'h000000;
      d_q <= 35'h000000000;
      bus.sck <= 1'b0;
      bus.chip_select_n <= 1'b1;
      bus.load_en <= 1'b0;
      bus.mosi <= 1'b0;
      bus.config_clk <= 1'b0;
      bus.config_valid <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (req_valid) begin
            a_q <= req_addr;
            d_q <= req_data;
            word_q <= 2'h0;
            cnt_q <= 2'h0;
            ph_q <= 1'b0;
            st_q <= ST_PRE;
          end
        end
        ST_PRE: if (tick) begin
          // RULE13: two clock pulses before select
          bus.sck <= ~ph_q;
          ph_q <= ~ph_q;
          if (ph_q) begin
            cnt_q <= cnt_q + 2'h1;
            if (cnt_q == scbl_pkg::PRE_PULSES - 2'h1) begin
              bus.chip_select_n <= 1'b0;
              sh_q <= {word[18:0], 1'b0};
              bus.mosi <= word[19];
              bit_q <= 5'h00;
              st_q <= ST_SHIFT;
            end
          end
        end
        ST_SHIFT: if (tick) begin
          // RULE6: data stable before rising edge, RULE20 MSB first
          bus.sck <= ~ph_q;
          ph_q <= ~ph_q;
          if (ph_q) begin
            if (bit_q == scbl_pkg::BIT_LAST) begin
              bus.chip_select_n <= 1'b1;
              cnt_q <= 2'h0;
              st_q <= ST_GAP1;
            end else begin
              bus.mosi <= sh_q[19];
              sh_q <= {sh_q[18:0], 1'b0};
              bit_q <= bit_q + 5'h01;
            end
          end
        end
        ST_GAP1: if (tick) begin
          // RULE9: load one serial period after select
          ph_q <= ~ph_q;
          if (ph_q) begin
            bus.load_en <= 1'b1;
            st_q <= ST_LOAD;
          end
        end
        ST_LOAD: if (tick) begin
          ph_q <= ~ph_q;
          if (ph_q) begin
            bus.load_en <= 1'b0;
            cnt_q <= 2'h0;
            st_q <= ST_GAP2;
          end
        end
        ST_GAP2: if (tick) begin
          // RULE10: config strobes two periods after load
          ph_q <= ~ph_q;
          if (ph_q) begin
            cnt_q <= cnt_q + 2'h1;
            if (cnt_q == scbl_pkg::VALID_GAP - 2'h2) begin
              bus.config_valid <= 1'b1;
              st_q <= ST_CFG;
            end
          end
        end
        ST_CFG: if (tick) begin
          // RULE11: valid high one period around config clock
          bus.config_clk <= ~ph_q;
          ph_q <= ~ph_q;
          if (ph_q) begin
            bus.config_valid <= 1'b0;
            cnt_q <= 2'h0;
            word_q <= word_q + 2'h1;
            st_q <= (word_q == 2'h3) ? ST_IDLE : ST_PRE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
endmodule : scbl_master

/* File: src/scbl_pkg.sv */
package scbl_pkg;
  // ----------------------------------------
  // Word format
  // ----------------------------------------
  localparam int WORD_W = 20;
  localparam int PAY_W = 18;
  localparam int POS_HALF = 19;
  localparam int POS_KIND = 18;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 35;
  localparam int UP_ADDR_W = 3;
  localparam int UP_DATA_W = 17;
  localparam logic [4:0] BIT_LAST = 5'h13;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int SCK_PERIOD_NS = 320;
  localparam int SCK_HALF_CYC = (SCK_PERIOD_NS * (CLK_HZ / 1000000)) / 2000;
  localparam logic [3:0] HALF_CNT = 4'(SCK_HALF_CYC - 1);
  localparam logic [1:0] PRE_PULSES = 2'h2;
  localparam logic [1:0] LOAD_GAP = 2'h1;
  localparam logic [1:0] VALID_GAP = 2'h2;
  localparam logic [1:0] BUF_DEPTH = 2'h2;
  // ----------------------------------------
  // Word kinds
  // ----------------------------------------
  typedef enum logic [1:0] {
    SCBL_UP_ADDR = 2'h0,
    SCBL_LO_ADDR = 2'h2,
    SCBL_UP_DATA = 2'h1,
    SCBL_LO_DATA = 2'h3
  } scbl_kind_t;
endpackage : scbl_pkg

/* File: src/scbl_if.sv */
`timescale 1ns/1ps
interface scbl_if;
  logic sck;
  logic chip_select_n;
  logic load_en;
  logic mosi;
  logic config_clk;
  logic config_valid;
  logic miso_o;
  logic miso_oe;
  logic miso;
  // Shared line resolves to pulled-high level when nobody drives
  assign miso = miso_oe ? miso_o : 1'b1;
  modport master (
    output sck, chip_select_n, load_en, mosi, config_clk, config_valid,
    input miso
  );
  modport slave (
    input sck, chip_select_n, load_en, mosi, config_clk, config_valid,
    output miso_o, miso_oe
  );
endinterface : scbl_if

/* File: src/scbl_buf2.sv */
`timescale 1ns/1ps
module scbl_buf2 #(
  parameter int W = 56
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_q [2];
  logic wp_q;
  logic rp_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;
  assign in_ready = (cnt_q != scbl_pkg::BUF_DEPTH);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // Storage
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end
  // Pointers and fill level
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : scbl_buf2

/* File: src/scbl_slave.sv */
`timescale 1ns/1ps
// Behaviour
// RULE1: bit19 upper/lower, bit18 address/data tag
// RULE2: upper address payload top bits zero
// RULE3: lower address gives address bits 17:0
// RULE4: data words give bits 34:18, 17:0
// RULE5: order upper/lower address then data
// RULE6: sample serial data on clock rise
// RULE7: shift while select low, capture on rise
// RULE8: load strobe rise latches holding register
// RULE9: load strobe one clock after select
// RULE10: config clock, valid two clocks later
// RULE11: valid pulses only with valid data
// RULE12: valid sampled by config clock
// RULE13: two clock pulses before select low
// RULE14: master drives lines, slave only MISO
// RULE15: unselected slaves ignore serial clock
// RULE16: shift contents held until next transaction
// RULE17: every word shifted as 20 bits
// RULE18: write only after lower data word
// RULE19: MISO driven only while addressed
// RULE20: most significant bit first
module scbl_slave (
  input wire logic core_clk,
  input wire logic srst,
  scbl_if.slave bus,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [20:0] wr_addr,
  output logic [34:0] wr_data
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  always_ff @(posedge core_clk) begin
    s1_q <= {bus.sck, bus.chip_select_n, bus.load_en, bus.config_clk};
    s2_q <= s1_q;
    s3_q <= s2_q;
  end
  logic mosi1_q;
  logic mosi2_q;
  logic cv1_q;
  logic cv2_q;
  always_ff @(posedge core_clk) begin
    mosi1_q <= bus.mosi;
    mosi2_q <= mosi1_q;
    cv1_q <= bus.config_valid;
    cv2_q <= cv1_q;
  end
  logic sck_rise;
  logic cs_rise;
  logic ld_rise;
  logic cc_rise;
  logic cs_low;
  assign sck_rise = s2_q[3] && !s3_q[3];
  assign cs_rise = s2_q[2] && !s3_q[2];
  assign ld_rise = s2_q[1] && !s3_q[1];
  assign cc_rise = s2_q[0] && !s3_q[0];
  assign cs_low = !s2_q[2];
  // ----------------------------------------
  // Shift and capture
  // ----------------------------------------
  logic [19:0] sh_q;
  logic [19:0] cap_q;
  logic [19:0] hold_q;
  logic sel_q;
  // RULE6: rising clock sample, RULE20 MSB first
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sh_q <= 20'h00000;
    end else if (sck_rise && cs_low) begin
      // RULE15: ignore clock when unselected
      sh_q <= {sh_q[18:0], mosi2_q};
    end
  end
  // RULE7: capture word on select rise
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cap_q <= 20'h00000;
      sel_q <= 1'b0;
    end else begin
      if (cs_rise) begin
        cap_q <= sh_q;
        sel_q <= 1'b1;
      end else if (ld_rise) begin
        sel_q <= 1'b0;
      end
    end
  end
  // RULE8: load strobe rise, RULE16 held until next
  // RULE15: load only after own frame
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hold_q <= 20'h00000;
    end else if (ld_rise && sel_q) begin
      hold_q <= cap_q;
    end
  end
  // RULE19: drive MISO only while addressed, MSB of shift
  assign bus.miso_o = sh_q[scbl_pkg::WORD_W-1];
  assign bus.miso_oe = cs_low;
  // ----------------------------------------
  // Packing on config clock
  // ----------------------------------------
  logic [20:0] addr_q;
  logic [34:0] data_q;
  logic go;
  logic bvalid;
  logic bready;
  logic [1:0] idx;
  logic [1:0] next_q;
  logic in_order;
  logic last_word;
  // RULE12: valid sampled by config clock edge
  assign go = cc_rise && cv2_q;
  // Word position 0..3 from the tag, in sending order
  assign idx = {hold_q[scbl_pkg::POS_KIND], hold_q[scbl_pkg::POS_HALF]};
  assign in_order = (idx == next_q);
  assign last_word = go && in_order && (idx == 2'h3);
  // RULE1, RULE3, RULE4, RULE17: unpack by tag
  always_ff @(posedge core_clk) begin
    if (srst) begin
      addr_q <= 21'h000000;
      data_q <= 35'h000000000;
    end else if (go) begin
      case (scbl_pkg::scbl_kind_t'({hold_q[scbl_pkg::POS_HALF], hold_q[scbl_pkg::POS_KIND]}))
        // RULE2: only low three payload bits used
        scbl_pkg::SCBL_UP_ADDR: addr_q[20:18] <= hold_q[2:0];
        scbl_pkg::SCBL_LO_ADDR: addr_q[17:0] <= hold_q[17:0];
        scbl_pkg::SCBL_UP_DATA: data_q[34:18] <= hold_q[16:0];
        default: data_q[17:0] <= hold_q[17:0];
      endcase
    end
  end
  // RULE5: expected next word of a write
  always_ff @(posedge core_clk) begin
    if (srst) begin
      next_q <= 2'h0;
    end else if (go) begin
      if (in_order) begin
        next_q <= next_q + 2'h1;
      end else if (idx == 2'h0) begin
        // Stray upper address starts a new write
        next_q <= 2'h1;
      end else begin
        next_q <= 2'h0;
      end
    end
  end
  // RULE18: write offered after ordered lower data word
  // Held until the buffer takes it; a new completion wins over the take
  // Limitation: words arriving while a write waits overwrite its fields
  always_ff @(posedge core_clk) begin
    if (srst) begin
      bvalid <= 1'b0;
    end else if (last_word) begin
      bvalid <= 1'b1;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end
  scbl_buf2 #(.W(56)) u_buf (
    .core_clk(core_clk),
    .srst(srst),
    .in_valid(bvalid),
    .in_ready(bready),
    .in_data({addr_q, data_q}),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data({wr_addr, wr_data})
  );
endmodule : scbl_slave

/* File: bench/scbl_sva.sv */
`timescale 1ns/1ps
module scbl_sva (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic sck,
  input wire logic chip_select_n,
  input wire logic load_en,
  input wire logic mosi,
  input wire logic config_clk,
  input wire logic config_valid,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic miso
);
  logic [4:0] bit_cnt_q;
  logic [2:0] pre_cnt_q;
  logic [2:0] hi_cnt_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  always_ff @(posedge core_clk) begin
    if (srst || $fell(chip_select_n)) begin
      bit_cnt_q <= 5'h0;
    end else if ($rose(sck) && !chip_select_n) begin
      bit_cnt_q <= bit_cnt_q + 5'h1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst || $fell(chip_select_n)) begin
      pre_cnt_q <= 3'h0;
    end else if ($rose(sck) && chip_select_n && pre_cnt_q != 3'h7) begin
      pre_cnt_q <= pre_cnt_q + 3'h1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst || !chip_select_n) begin
      hi_cnt_q <= 3'h0;
    end else if (hi_cnt_q != 3'h7) begin
      hi_cnt_q <= hi_cnt_q + 3'h1;
    end
  end
  a_reset_idle_lines: assert property (disable iff (1'b0)
    srst |=> chip_select_n && !load_en && !config_valid) else $error("idle levels wrong");
  a_frame_bit_count: assert property (
    $rose(chip_select_n) |-> bit_cnt_q == 5'h14) else $error("frame not 20 bits");
  a_pre_clock_pulses: assert property (
    $fell(chip_select_n) |-> pre_cnt_q >= 3'h2) else $error("missing lead pulses");
  a_mosi_stable_rise: assert property (
    $rose(sck) && !chip_select_n |-> $stable(mosi)) else $error("mosi moved at rise");
  a_load_after_select: assert property (
    $rose(chip_select_n) |-> !load_en [*4] ##[1:12] $rose(load_en)) else $error("load late");
  a_load_deselected: assert property (
    load_en |-> chip_select_n) else $error("load during frame");
  a_valid_after_load: assert property (
    $rose(load_en) |-> !config_valid [*8] ##[1:24] $rose(config_valid)) else $error("valid gap");
  a_clk_with_valid: assert property (
    $rose(config_clk) |-> config_valid) else $error("config clock without valid");
  a_miso_when_select: assert property (
    miso_oe |-> hi_cnt_q < 3'h5) else $error("miso driven unselected");
  a_miso_released: assert property (
    !miso_oe |-> miso) else $error("released miso not high");
  a_miso_follows: assert property (
    miso_oe |-> miso == miso_o) else $error("miso not from slave");
  c_valid: cover property ($rose(config_valid));
  c_miso: cover property ($rose(miso_oe));
  c_load_valid: cover property ($rose(load_en) ##[1:40] $rose(config_valid));
endmodule : scbl_sva

/* File: bench/tb.sv */
`timescale 1ns/1ps
module tb;
  logic core_clk;
  logic srst;
  logic req_valid;
  logic req_ready;
  logic [20:0] req_addr;
  logic [34:0] req_data;
  logic busy;
  logic wr_valid;
  logic wr_ready;
  logic [20:0] wr_addr;
  logic [34:0] wr_data;
  logic [55:0] exp_q[$];
  logic [55:0] exp_v;
  logic stall;
  int fail_count;
  int n_compared;
  int seed;
  int k;
  scbl_if bus_if();
  scbl_master i_scbl_master (.core_clk(core_clk), .srst(srst), .bus(bus_if),
    .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr),
    .req_data(req_data), .busy(busy));
  scbl_slave i_scbl_slave (.core_clk(core_clk), .srst(srst), .bus(bus_if),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data));
  scbl_sva i_scbl_sva (.core_clk(core_clk), .srst(srst), .sck(bus_if.sck),
    .chip_select_n(bus_if.chip_select_n), .load_en(bus_if.load_en), .mosi(bus_if.mosi),
    .config_clk(bus_if.config_clk), .config_valid(bus_if.config_valid),
    .miso_o(bus_if.miso_o), .miso_oe(bus_if.miso_oe), .miso(bus_if.miso));
  // Clock generation
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Receiver stalls at random
  always @(posedge core_clk) begin
    #1 wr_ready = stall ? 1'($random(seed)) : 1'b1;
  end
  // Compare each delivered write with the oldest note
  always @(negedge core_clk) begin
    if (srst === 1'b0 && wr_valid === 1'b1 && wr_ready === 1'b1) begin
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 56'hX;
      n_compared++;
      if ({wr_addr, wr_data} !== exp_v) begin
        fail_count++;
        $display("[FAIL] %0t got %h exp %h", $time, {wr_addr, wr_data}, exp_v);
      end
    end
  end
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  // One configuration write through the master
  task automatic send(input logic [20:0] a, input logic [34:0] d);
    int i;
    i = 0;
    @(posedge core_clk);
    #1 req_valid = 1'b1;
    req_addr = a;
    req_data = d;
    while (req_ready !== 1'b1 && i < 4000) begin
      @(posedge core_clk);
      #1 i++;
    end
    if (i == 4000) begin
      fail_count++;
      test_done();
    end
    exp_q.push_back({a, d});
    @(posedge core_clk);
    #1 req_valid = 1'b0;
  endtask : send
  task automatic drain(input string name);
    int i;
    for (i = 0; i < 8000 && (exp_q.size() > 0 || busy !== 1'b0); i++) begin
      @(posedge core_clk);
    end
    if (i == 8000) begin
      fail_count++;
      test_done();
    end
    $display("test %s done", name);
  endtask : drain
  // Main sequence
  initial begin
    seed = 32'hD585;
    srst = 1'b1;
    req_valid = 1'b0;
    req_addr = 21'h0;
    req_data = 35'h0;
    stall = 1'b0;
    repeat (20) @(posedge core_clk);
    #1 srst = 1'b0;
    send(21'h000000, 35'h000000000);
    send(21'h1FFFFF, 35'h7FFFFFFFF);
    send(21'h0AAAAA, 35'h555555555);
    drain("boundary");
    stall = 1'b1;
    for (k = 0; k < 6; k++) begin
      send(21'($random(seed)), 35'({$random(seed), $random(seed)}));
    end
    stall = 1'b0;
    drain("random stall");
    test_done();
  end
endmodule : tb
